// ### pkg/input_port_pkg.sv
// Purpose: Shared constants for the shared input port sampler.
// Assumes: Word index addressing, byte address is four times the index.
// Notes: Terminal k belongs to module k/10, bit k%10 of that module's word.
package input_port_pkg;

    // ========================================
    // Geometry
    localparam int NUM_TERMINALS = 20;
    localparam int TERMS_PER_MODULE = 10;
    localparam int WORD_WIDTH = 16;
    localparam int FUNC_WIDTH = 3;
    localparam int CODE_WIDTH = 3;
    localparam int CNT_WIDTH = 7;

    // ========================================
    // Register indices (byte address = index * 4)
    localparam logic [13:0] IDX_MODULE0_INPUT_WORD = 14'hb90;
    localparam logic [13:0] IDX_MODULE1_INPUT_WORD = 14'hb92;
    localparam logic [13:0] IDX_FILTER_CONFIG = 14'hb80;
    localparam logic [13:0] IDX_FUNCTION_SELECT0 = 14'hb81;
    localparam logic [13:0] IDX_FUNCTION_SELECT1 = 14'hb82;

    // ========================================
    // Field layout and reset values
    localparam int FILTER_CODE_LSB = 0;
    localparam logic [CODE_WIDTH-1:0] FILTER_CODE_RESET = 3'h5;
    localparam logic [31:0] FUNCTION_SELECT_RESET = 32'h0000_0000;

    // Terminal functions; codes above FUNC_ORIGIN leave the pin unused
    localparam logic [FUNC_WIDTH-1:0] FUNC_NORMAL = 3'h0;
    localparam logic [FUNC_WIDTH-1:0] FUNC_INTERRUPT = 3'h1;
    localparam logic [FUNC_WIDTH-1:0] FUNC_QUICK = 3'h2;
    localparam logic [FUNC_WIDTH-1:0] FUNC_COUNTER = 3'h3;
    localparam logic [FUNC_WIDTH-1:0] FUNC_ORIGIN = 3'h4;

    // ========================================
    // Timing: filter base step of 0.5 ms at 100 MHz
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int FILTER_STEP_NS = 500000;
    localparam int FILTER_STEP_CYCLES = FILTER_STEP_NS / CLOCK_PERIOD_NS;

    // Code 0 no filter, code n gives 2^(n-1) steps: 0.5,1,2,4,8,16,32 ms
    function automatic logic [CNT_WIDTH-1:0] filter_steps(input logic [CODE_WIDTH-1:0] code);
        logic [CNT_WIDTH-1:0] one;
        one = 7'h01;
        if (code == 3'h0) begin
            filter_steps = 7'h00;
        end else begin
            filter_steps = one << (code - 3'h1);
        end
    endfunction : filter_steps

    // Byte-lane merge for 32-bit writes
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        lane_merge = res;
    endfunction : lane_merge

endpackage : input_port_pkg

// ### hw/input_filter.sv
// Purpose: Per-terminal ON/OFF input filter.
// Assumes: step_tick is a one-cycle pulse every filter step.
// Notes: Response time is steps-1 to steps step periods, the tick phase is free running.
`timescale 1ns/1ps
`default_nettype none

module input_filter
    import input_port_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Control
    input wire logic step_tick,
    input wire logic [CODE_WIDTH-1:0] filter_code,
    // Terminals
    input wire logic [NUM_TERMINALS-1:0] raw_level,
    output logic [NUM_TERMINALS-1:0] filtered_level
);

    // ========================================
    // State
    typedef struct packed {
        logic [NUM_TERMINALS-1:0][CNT_WIDTH-1:0] cnt;
        logic [NUM_TERMINALS-1:0] level;
    } filter_state_s;

    filter_state_s state_ff;
    filter_state_s nxt_state;
    logic [CNT_WIDTH-1:0] limit;

    assign limit = filter_steps(filter_code);

    // A change must persist for the whole constant, else the count restarts
    always_comb begin
        nxt_state = state_ff;
        for (int i = 0; i < NUM_TERMINALS; i++) begin
            if (limit == 7'h00) begin
                nxt_state.level[i] = raw_level[i];
                nxt_state.cnt[i] = 7'h00;
            end else if (raw_level[i] == state_ff.level[i]) begin
                nxt_state.cnt[i] = 7'h00;
            end else if (step_tick) begin
                if (state_ff.cnt[i] + 7'h01 >= limit) begin
                    nxt_state.level[i] = raw_level[i];
                    nxt_state.cnt[i] = 7'h00;
                end else begin
                    nxt_state.cnt[i] = state_ff.cnt[i] + 7'h01;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign filtered_level = state_ff.level;

endmodule : input_filter

`default_nettype wire

// ### hw/function_router.sv
// Purpose: Steers each filtered terminal to at most one function, none for codes above FUNC_ORIGIN.
// Assumes: Function codes come from the select registers.
// Notes: Purely combinational; the top registers the results.
`timescale 1ns/1ps
`default_nettype none

module function_router
    import input_port_pkg::*;
(
    // Filtered terminals and selection
    input wire logic [NUM_TERMINALS-1:0] level,
    input wire logic [NUM_TERMINALS-1:0][FUNC_WIDTH-1:0] func_sel,
    // Routed results
    output logic [NUM_TERMINALS-1:0] normal_mask,
    output logic [NUM_TERMINALS-1:0] interrupt_level,
    output logic [NUM_TERMINALS-1:0] quick_level,
    output logic [NUM_TERMINALS-1:0] counter_level,
    output logic [NUM_TERMINALS-1:0] origin_level
);

    // One code per terminal, so no two functions can claim the same pin
    always_comb begin
        normal_mask = '0;
        interrupt_level = '0;
        quick_level = '0;
        counter_level = '0;
        origin_level = '0;
        for (int i = 0; i < NUM_TERMINALS; i++) begin
            normal_mask[i] = (func_sel[i] == FUNC_NORMAL);
            interrupt_level[i] = level[i] & (func_sel[i] == FUNC_INTERRUPT);
            quick_level[i] = level[i] & (func_sel[i] == FUNC_QUICK);
            counter_level[i] = level[i] & (func_sel[i] == FUNC_COUNTER);
            origin_level[i] = level[i] & (func_sel[i] == FUNC_ORIGIN);
        end
    end

endmodule : function_router

`default_nettype wire

// ### hw/shared_input_port_sampler.sv
// Purpose: Normal-input port of a pulse I/O expansion, two modules of ten terminals.
// Assumes: refresh_strobe marks each controller I/O refresh; pins synchronous to clock.
// Notes: Registers on classic Wishbone, 32-bit data, byte address = index * 4.
//
// Overview of operation
// - Each refresh stores every normal-input terminal level into its memory bit.
// - A configurable filter delays both ON and OFF changes before storage.
// - Filter defaults to 8 ms; choices none, 0.5, 1, 2, 4, 8, 16, 32 ms.
// - Module 0 fills bits 0-9 of word 2960, module 1 bits 0-9 of 2962.
// - Each terminal serves at most one function at any time; codes above 4 select none.
// - Module 0 terminal 2 as normal input drives no counter, quick, interrupt, origin.
`timescale 1ns/1ps
`default_nettype none

module shared_input_port_sampler
    import input_port_pkg::*;
#(
    parameter int STEP_CYCLES = FILTER_STEP_CYCLES
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Controller refresh
    input wire logic refresh_strobe,
    // Field terminals, bit k is module k/10 terminal k%10
    input wire logic [NUM_TERMINALS-1:0] input_terminal,
    // Alternate-function levels
    output logic [NUM_TERMINALS-1:0] interrupt_input,
    output logic [NUM_TERMINALS-1:0] quick_response_input,
    output logic [NUM_TERMINALS-1:0] counter_input,
    output logic [NUM_TERMINALS-1:0] origin_search_input
);

    // ========================================
    // State
    typedef struct packed {
        logic [31:0] step_cnt;
        logic step_tick;
        logic [CODE_WIDTH-1:0] filter_code;
        logic [31:0] func_sel0;
        logic [31:0] func_sel1;
        logic [TERMS_PER_MODULE-1:0] module0_word;
        logic [TERMS_PER_MODULE-1:0] module1_word;
        logic [NUM_TERMINALS-1:0] intr;
        logic [NUM_TERMINALS-1:0] quick;
        logic [NUM_TERMINALS-1:0] count;
        logic [NUM_TERMINALS-1:0] origin;
        logic ack;
        logic [31:0] rdata;
    } port_state_s;

    port_state_s state_ff;
    port_state_s nxt_state;

    logic [NUM_TERMINALS-1:0] filtered;
    logic [NUM_TERMINALS-1:0][FUNC_WIDTH-1:0] func_sel;
    logic [NUM_TERMINALS-1:0] normal_mask;
    logic [NUM_TERMINALS-1:0] intr_lvl;
    logic [NUM_TERMINALS-1:0] quick_lvl;
    logic [NUM_TERMINALS-1:0] count_lvl;
    logic [NUM_TERMINALS-1:0] origin_lvl;
    logic [13:0] word_idx;
    logic bus_req;
    logic [31:0] step_last;

    assign word_idx = wb_adr_i[15:2];
    assign bus_req = wb_cyc_i & wb_stb_i & ~state_ff.ack;
    assign step_last = STEP_CYCLES - 1;

    // ========================================
    // Function selection, three bits per terminal
    always_comb begin
        for (int t = 0; t < TERMS_PER_MODULE; t++) begin
            func_sel[t] = state_ff.func_sel0[t*FUNC_WIDTH +: FUNC_WIDTH];
            func_sel[t+TERMS_PER_MODULE] = state_ff.func_sel1[t*FUNC_WIDTH +: FUNC_WIDTH];
        end
    end

    // ========================================
    // Filter and router
    input_filter u_filter (
        .clock(clock),
        .rstn(rstn),
        .step_tick(state_ff.step_tick),
        .filter_code(state_ff.filter_code),
        .raw_level(input_terminal),
        .filtered_level(filtered)
    );

    function_router u_router (
        .level(filtered),
        .func_sel(func_sel),
        .normal_mask(normal_mask),
        .interrupt_level(intr_lvl),
        .quick_level(quick_lvl),
        .counter_level(count_lvl),
        .origin_level(origin_lvl)
    );

    // ========================================
    // Next state
    always_comb begin
        nxt_state = state_ff;

        // Filter step divider, one-cycle enable
        nxt_state.step_tick = 1'b0;
        if (state_ff.step_cnt >= step_last) begin
            nxt_state.step_cnt = 32'h0000_0000;
            nxt_state.step_tick = 1'b1;
        end else begin
            nxt_state.step_cnt = state_ff.step_cnt + 32'h0000_0001;
        end

        // Alternate functions follow the filtered pin continuously
        nxt_state.intr = intr_lvl;
        nxt_state.quick = quick_lvl;
        nxt_state.count = count_lvl;
        nxt_state.origin = origin_lvl;

        // Refresh copies only normal-input terminals; others keep their bit
        if (refresh_strobe) begin
            for (int t = 0; t < TERMS_PER_MODULE; t++) begin
                if (normal_mask[t]) begin
                    nxt_state.module0_word[t] = filtered[t];
                end
                if (normal_mask[t+TERMS_PER_MODULE]) begin
                    nxt_state.module1_word[t] = filtered[t+TERMS_PER_MODULE];
                end
            end
        end

        // Wishbone: one wait state, ack drops the cycle after it rose
        nxt_state.ack = bus_req;
        if (bus_req) begin
            nxt_state.rdata = 32'h0000_0000;
            unique case (word_idx)
                IDX_MODULE0_INPUT_WORD: begin
                    nxt_state.rdata[TERMS_PER_MODULE-1:0] = state_ff.module0_word;
                end
                IDX_MODULE1_INPUT_WORD: begin
                    nxt_state.rdata[TERMS_PER_MODULE-1:0] = state_ff.module1_word;
                end
                IDX_FILTER_CONFIG: begin
                    nxt_state.rdata[FILTER_CODE_LSB +: CODE_WIDTH] = state_ff.filter_code;
                end
                IDX_FUNCTION_SELECT0: begin
                    nxt_state.rdata = state_ff.func_sel0;
                end
                IDX_FUNCTION_SELECT1: begin
                    nxt_state.rdata = state_ff.func_sel1;
                end
                default: begin
                    nxt_state.rdata = 32'h0000_0000;
                end
            endcase
            if (wb_we_i) begin
                unique case (word_idx)
                    IDX_FILTER_CONFIG: begin
                        if (wb_sel_i[0]) begin
                            nxt_state.filter_code = wb_dat_i[FILTER_CODE_LSB +: CODE_WIDTH];
                        end
                    end
                    IDX_FUNCTION_SELECT0: begin
                        nxt_state.func_sel0 = lane_merge(state_ff.func_sel0, wb_dat_i, wb_sel_i);
                    end
                    IDX_FUNCTION_SELECT1: begin
                        nxt_state.func_sel1 = lane_merge(state_ff.func_sel1, wb_dat_i, wb_sel_i);
                    end
                    default: begin
                        // Input words are read-only; unmapped writes are acked and dropped
                        nxt_state.filter_code = state_ff.filter_code;
                    end
                endcase
            end
        end
    end

    // ========================================
    // Registers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_ff <= '0;
            state_ff.filter_code <= FILTER_CODE_RESET;
            state_ff.func_sel0 <= FUNCTION_SELECT_RESET;
            state_ff.func_sel1 <= FUNCTION_SELECT_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ========================================
    // Outputs
    assign wb_ack_o = state_ff.ack;
    assign wb_dat_o = state_ff.rdata;
    assign interrupt_input = state_ff.intr;
    assign quick_response_input = state_ff.quick;
    assign counter_input = state_ff.count;
    assign origin_search_input = state_ff.origin;

endmodule : shared_input_port_sampler

`default_nettype wire

// ### tb/field_switch_model.sv
// Purpose: Field switch and sensor levels on the twenty input terminals.
// Assumes: Levels are commanded by the bench and change just after a clock edge.
// Notes: Ideal contacts; filter timing is exercised with long level steps.
`timescale 1ns/1ps
`default_nettype none

module field_switch_model
    import input_port_pkg::*;
(
    // Clock
    input wire logic clock,
    // Commanded and driven levels
    input wire logic [NUM_TERMINALS-1:0] want,
    output logic [NUM_TERMINALS-1:0] input_terminal
);
    // ========================================
    // Terminal drive; the sampler is held in reset long enough for this flop to settle
    // One flop keeps pin edges off the sampling edge of the sampler
    always @(posedge clock) begin
        input_terminal <= want;
    end
endmodule : field_switch_model
`default_nettype wire

// ### tb/sampler_props.sv
// Purpose: Port-level checks of the shared input port sampler.
// Assumes: Code of module 0 terminal 2 is tracked from bus writes.
// Notes: Bound into every sampler instance.
`timescale 1ns/1ps
`default_nettype none

module sampler_props
    import input_port_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Alternate functions
    input wire logic [NUM_TERMINALS-1:0] interrupt_input,
    input wire logic [NUM_TERMINALS-1:0] quick_response_input,
    input wire logic [NUM_TERMINALS-1:0] counter_input,
    input wire logic [NUM_TERMINALS-1:0] origin_search_input
);
    // ========================================
    // Helper state
    logic take;
    logic rd_word;
    logic [FUNC_WIDTH-1:0] t2_ff;
    logic [FUNC_WIDTH-1:0] t2_old_ff;
    logic [13:0] idx_ff;
    logic [3:0] alt2;
    logic [3:0] own2;
    logic [NUM_TERMINALS-1:0] multi;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd_word = idx_ff == IDX_MODULE0_INPUT_WORD || idx_ff == IDX_MODULE1_INPUT_WORD;
    assign alt2 = {origin_search_input[2], counter_input[2], quick_response_input[2],
                   interrupt_input[2]};
    // Outputs lag the code by a cycle, so either the old or the new code may own a bit
    for (genvar k = 0; k < 4; k++) begin : g_own
        assign own2[k] = t2_ff == 3'(k + 1) || t2_old_ff == 3'(k + 1);
    end
    assign multi = (interrupt_input & (quick_response_input | counter_input | origin_search_input))
                 | (quick_response_input & (counter_input | origin_search_input))
                 | (counter_input & origin_search_input);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            t2_ff <= FUNC_NORMAL;
            t2_old_ff <= FUNC_NORMAL;
            idx_ff <= 14'h0000;
        end else begin
            t2_old_ff <= t2_ff;
            if (take) begin
                idx_ff <= wb_adr_i[15:2];
            end
            if (take && wb_we_i && wb_adr_i[15:2] == IDX_FUNCTION_SELECT0) begin
                t2_ff <= {wb_sel_i[1] ? wb_dat_i[8] : t2_ff[2],
                          wb_sel_i[0] ? wb_dat_i[7:6] : t2_ff[1:0]};
            end
        end
    end

    // ========================================
    // Assertions
    ack_one_cycle_a: assert property (@(posedge clock) disable iff (!rstn)
        wb_ack_o |=> !wb_ack_o) else $error("ack held for more than one cycle");
    ack_next_cycle_a: assert property (@(posedge clock) disable iff (!rstn)
        take |=> wb_ack_o) else $error("request not answered in the next cycle");
    one_function_a: assert property (@(posedge clock) disable iff (!rstn)
        multi == 20'h0) else $error("terminal drives two functions");
    word_high_zero_a: assert property (@(posedge clock) disable iff (!rstn)
        wb_ack_o && !wb_we_i && rd_word |-> wb_dat_o[31:10] == 22'h0)
        else $error("input word has bits above 9 set");
    filter_field_a: assert property (@(posedge clock) disable iff (!rstn)
        wb_ack_o && !wb_we_i && idx_ff == IDX_FILTER_CONFIG |-> wb_dat_o[31:3] == 29'h0)
        else $error("filter config has bits above 2 set");
    normal_term2_a: assert property (@(posedge clock) disable iff (!rstn)
        t2_ff == FUNC_NORMAL && t2_old_ff == FUNC_NORMAL |-> alt2 == 4'h0)
        else $error("normal terminal 2 drives an alternate function");
    alt_route_a: assert property (@(posedge clock) disable iff (!rstn)
        (alt2 & ~own2) == 4'h0) else $error("terminal 2 level reaches an unselected function");
endmodule : sampler_props

bind shared_input_port_sampler sampler_props sampler_props_i (
    .clock(clock), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .interrupt_input(interrupt_input),
    .quick_response_input(quick_response_input), .counter_input(counter_input),
    .origin_search_input(origin_search_input));
`default_nettype wire

// ### tb/tb.sv
// Purpose: Self-checking bench of the shared input port sampler.
// Assumes: Filter step shortened to four cycles.
// Notes: Refresh strobe is held high except where a test stops it.
`timescale 1ns/1ps
`default_nettype none

module tb
    import input_port_pkg::*;
;
    localparam int STEP = 4;
    localparam logic [19:0] PAT = 20'ha5c93;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [15:0] wb_adr_i = 16'h0000;
    logic [31:0] wb_dat_i = 32'h0;
    logic refresh_strobe = 1'b1;
    logic [NUM_TERMINALS-1:0] want = '0;
    logic [NUM_TERMINALS-1:0] input_terminal, irq, quick, cnt, orig;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    int errors = 0;
    int n_tests = 0;
    always #5 clock = ~clock;

    field_switch_model field_switch_model_i (.clock(clock), .want(want),
        .input_terminal(input_terminal));
    shared_input_port_sampler #(.STEP_CYCLES(STEP)) shared_input_port_sampler_i (
        .clock(clock), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .refresh_strobe(refresh_strobe),
        .input_terminal(input_terminal), .interrupt_input(irq),
        .quick_response_input(quick), .counter_input(cnt), .origin_search_input(orig));

    // ========================================
    // Shared tasks
    task automatic results();
        $display("errors %0d of %0d checks", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    task automatic bus(input logic we, input logic [13:0] idx, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= d;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            results();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clock);
    endtask : bus

    // ========================================
    // Scenarios
    task automatic reset_values();
        logic [31:0] q;
        bus(1'b0, IDX_FILTER_CONFIG, 32'h0, q);
        check(q, {29'h0, FILTER_CODE_RESET});
        bus(1'b0, IDX_FUNCTION_SELECT1, 32'h0, q);
        check(q, FUNCTION_SELECT_RESET);
        bus(1'b0, 14'h0100, 32'h0, q);
        check(q, 32'h0);
    endtask : reset_values

    task automatic normal_map();
        logic [31:0] q;
        bus(1'b1, IDX_FILTER_CONFIG, 32'h0, q);
        want <= PAT;
        tick(4);
        bus(1'b1, IDX_MODULE0_INPUT_WORD, 32'hffffffff, q);
        bus(1'b0, IDX_MODULE0_INPUT_WORD, 32'h0, q);
        check(q, {22'h0, PAT[9:0]});
        refresh_strobe <= 1'b0;
        want <= ~PAT;
        tick(4);
        bus(1'b0, IDX_MODULE1_INPUT_WORD, 32'h0, q);
        check(q, {22'h0, PAT[19:10]});
        refresh_strobe <= 1'b1;
        tick(2);
        bus(1'b0, IDX_MODULE1_INPUT_WORD, 32'h0, q);
        check(q, {22'h0, ~PAT[19:10]});
    endtask : normal_map

    task automatic filter_times();
        logic [31:0] q;
        int steps;
        logic lvl;
        for (int c = 1; c <= 7; c++) begin
            steps = 1 << (c - 1);
            bus(1'b1, IDX_FILTER_CONFIG, 32'(c), q);
            for (int k = 0; k < 2; k++) begin
                lvl = ~want[0];
                want[0] <= lvl;
                // Early look stays below the shortest legal response
                if (steps > 1) begin
                    tick((steps - 1) * STEP - 3);
                    bus(1'b0, IDX_MODULE0_INPUT_WORD, 32'h0, q);
                    check({31'h0, q[0]}, {31'h0, ~lvl});
                end
                tick(12);
                bus(1'b0, IDX_MODULE0_INPUT_WORD, 32'h0, q);
                check({31'h0, q[0]}, {31'h0, lvl});
            end
        end
    endtask : filter_times

    task automatic functions();
        logic [31:0] q;
        logic [3:0] exp;
        bus(1'b1, IDX_FILTER_CONFIG, 32'h0, q);
        for (int c = 1; c <= 5; c++) begin
            exp = (c < 5) ? 4'h1 << (c - 1) : 4'h0;
            want[2] <= 1'b0;
            want[12] <= 1'b0;
            bus(1'b1, IDX_FUNCTION_SELECT0, 32'h0, q);
            bus(1'b1, IDX_FUNCTION_SELECT1, 32'h0, q);
            tick(4);
            bus(1'b1, IDX_FUNCTION_SELECT0, {23'h0, 3'(c), 6'h0}, q);
            bus(1'b1, IDX_FUNCTION_SELECT1, {23'h0, 3'(c), 6'h0}, q);
            want[2] <= 1'b1;
            want[12] <= 1'b1;
            tick(4);
            check({28'h0, orig[2], cnt[2], quick[2], irq[2]}, {28'h0, exp});
            check({28'h0, orig[12], cnt[12], quick[12], irq[12]}, {28'h0, exp});
            bus(1'b0, IDX_MODULE0_INPUT_WORD, 32'h0, q);
            check({31'h0, q[2]}, 32'h0);
            bus(1'b0, IDX_MODULE1_INPUT_WORD, 32'h0, q);
            check({31'h0, q[2]}, 32'h0);
        end
        bus(1'b1, IDX_FUNCTION_SELECT0, 32'h0, q);
        tick(4);
        bus(1'b0, IDX_MODULE0_INPUT_WORD, 32'h0, q);
        check({31'h0, q[2]}, 32'h1);
        check({28'h0, orig[2], cnt[2], quick[2], irq[2]}, 32'h0);
    endtask : functions

    initial begin
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        reset_values();
        normal_map();
        filter_times();
        functions();
        results();
    end
endmodule : tb
`default_nettype wire
